// ==== common/bfhrc_defines.vh ====
// Constants for the bus termination, fault, halt and reset control block.
// Assumes a 20 MHz processor clock; included by bare name from logic files.
`ifndef BFHRC_DEFINES_VH
`define BFHRC_DEFINES_VH
`define BFHRC_CLK_NS 50
`define BFHRC_STROBE_HALF_PERIODS 5
`define BFHRC_STROBE_CYC ((`BFHRC_STROBE_HALF_PERIODS + 1) / 2)
`define BFHRC_RST_OUT_CYC 124
`define BFHRC_RST_IN_CYC 10
`define BFHRC_VEC_SSP 24'h000000
`define BFHRC_VEC_PC 24'h000004
`define BFHRC_VEC_FAULT 24'h000008
`define BFHRC_STACK_WORDS 7
`define BFHRC_IPL_RESET 3'h7
`endif

// ==== logic/bfhrc_top.v ====
// Bus cycle termination, fault exception, halt, re-run and reset control.
// Assumes external acknowledge, fault, halt and reset lines are asynchronous;
// the core asks for cycles by START_REQ and executes instructions by INSN_START.
//
// Operation
// - On fault, end the cycle; drop address strobe 3 clocks later (2.5 rounded up).
// - Float buses while fault input held; stack once it is released.
// - Fault sequence: push PC and status, push error info, fetch vector, run.
// - Fault with halt held: end cycle, float buses, wait for halt release.
// - After re-run halt release, repeat cycle with same codes, data, controls.
// - Never re-run read-modify-write; fault plus halt then gives exception.
// - Halt held means no activity; halt released means normal execution.
// - Debug logic releases halt until a cycle starts, giving one cycle per step.
// - After a cycle completes with halt seen, float address and data buses, except after a stack push or the stack pointer vector fetch.
// - Arbitration runs while halted; only arbitration and reset three-state control signals.
// - A second fault before the next instruction halts the device.
// - Re-runs are not faults, do not count as doubles, and repeat freely.
// - Fault during reset vector fetch or before first instruction halts.
// - Reset loads supervisor stack pointer from vector 0, then PC from vector 1.
// - Reset sets interrupt level seven and leaves other registers untouched.
// - Reset instruction drives reset line 124 clocks, no internal change.
// - Insert one-clock wait states until acknowledge, with no limit.
// - Asynchronous inputs are synchronised within about two clocks.
`include "bfhrc_defines.vh"

module bfhrc_top #(
  parameter AW = 24,
  parameter DW = 8
) (
  // Clock and reset.
  input wire MCLK,
  input wire RST_B,
  // Bus handshake pins, active low except the HALT_OE and RESET_OE enables.
  input wire TRANSFER_ACKNOWLEDGE_B,
  input wire BUS_FAULT_INPUT_B,
  input wire HALT_IN_B,
  output reg HALT_OUT_B,
  output reg HALT_OE,
  input wire RESET_IN_B,
  output reg RESET_OUT_B,
  output reg RESET_OE,
  output reg ADDRESS_STROBE_B,
  // Arbitration three-state request.
  input wire ARB_TRISTATE,
  output reg CTRL_OE,
  // Address, data and function codes.
  output reg [AW-1:0] ADDR,
  output reg ADDR_OE,
  output reg [DW-1:0] WDATA,
  output reg DATA_OE,
  output reg [2:0] FUNC_CODE,
  output reg WRITE_OUT,
  // Core request side.
  input wire START_REQ,
  input wire [AW-1:0] REQ_ADDR,
  input wire [DW-1:0] REQ_WDATA,
  input wire [2:0] REQ_FC,
  input wire REQ_WRITE,
  input wire REQ_RMW,
  input wire INSN_START,
  input wire RESET_INSN,
  input wire [AW-1:0] PC_IN,
  // Core answer side.
  output reg CYCLE_DONE,
  output reg FAULT_VEC_REQ,
  output reg LOAD_SSP,
  output reg LOAD_PC,
  output reg [2:0] IPL_MASK,
  output reg HALTED,
  output reg DOUBLE_FAULT
);

  // States, one-hot.
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_BUS = 9'h002;
  localparam [8:0] S_END = 9'h004;
  localparam [8:0] S_FLOAT = 9'h008;
  localparam [8:0] S_RERUN = 9'h010;
  localparam [8:0] S_STACK = 9'h020;
  localparam [8:0] S_VEC = 9'h040;
  localparam [8:0] S_HALT = 9'h080;
  localparam [8:0] S_LOCK = 9'h100;

  localparam [1:0] K_NORM = 2'h0;
  localparam [1:0] K_SSP = 2'h1;
  localparam [1:0] K_PC = 2'h2;
  localparam [1:0] K_FVEC = 2'h3;

  // Counts held at full width here and cut to their counter widths where loaded.
  localparam [31:0] RST_PULSE = `BFHRC_RST_OUT_CYC;
  localparam [31:0] STACK_N = `BFHRC_STACK_WORDS;

  // Two-flop synchronisers for asynchronous pins.
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  always @(posedge MCLK) begin
    if (!RST_B) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {~TRANSFER_ACKNOWLEDGE_B, ~BUS_FAULT_INPUT_B, ~HALT_IN_B, ~RESET_IN_B};
      sync2_q <= sync1_q;
    end
  end
  wire ack = sync2_q[3];
  wire flt = sync2_q[2];
  wire hlt = sync2_q[1];
  wire rst_in = sync2_q[0];

  reg [8:0] st_q;
  reg [1:0] kind_q;
  reg [AW-1:0] addr_q;
  reg [DW-1:0] wd_q;
  reg [2:0] fc_q;
  reg wr_q;
  reg rmw_q;
  reg fault_pend_q;
  reg post_reset_q;
  reg [2:0] cnt_q;
  reg [2:0] stk_q;
  reg [6:0] rcnt_q;
  reg [3:0] rin_q;
  reg reset_seq_q;

  // External system reset needs halt and reset together for ten clocks.
  wire sys_rst = (rin_q == `BFHRC_RST_IN_CYC) && !reset_seq_q;
  always @(posedge MCLK) begin
    if (!RST_B) begin
      rin_q <= 4'h0;
    end else if (rst_in && hlt && RESET_OE == 1'b0) begin
      if (rin_q != `BFHRC_RST_IN_CYC)
        rin_q <= rin_q + 4'h1;
    end else begin
      rin_q <= 4'h0;
    end
  end

  // Reset instruction pulse counter on the reset line.
  always @(posedge MCLK) begin
    if (!RST_B) begin
      rcnt_q <= 7'h00;
      RESET_OUT_B <= 1'b1;
      RESET_OE <= 1'b0;
    end else if (rcnt_q != 7'h00) begin
      rcnt_q <= rcnt_q - 7'h01;
      RESET_OE <= (rcnt_q != 7'h01);
      RESET_OUT_B <= (rcnt_q == 7'h01);
    end else if (RESET_INSN) begin
      rcnt_q <= RST_PULSE[6:0];
      RESET_OE <= 1'b1;
      RESET_OUT_B <= 1'b0;
    end
  end

  // Halt output is never driven; lockup is shown on HALTED instead.
  always @(posedge MCLK) begin
    HALT_OUT_B <= 1'b1;
    HALT_OE <= 1'b0;
    CTRL_OE <= RST_B & ~ARB_TRISTATE;
  end

  // Main sequencer: cycle launch, termination, exception and halt.
  always @(posedge MCLK) begin
    if (!RST_B || sys_rst) begin
      st_q <= S_VEC;
      kind_q <= K_SSP;
      reset_seq_q <= 1'b1;
      post_reset_q <= 1'b1;
      fault_pend_q <= 1'b0;
      addr_q <= `BFHRC_VEC_SSP;
      wd_q <= {DW{1'b0}};
      fc_q <= 3'h6;
      wr_q <= 1'b0;
      rmw_q <= 1'b0;
      cnt_q <= 3'h0;
      stk_q <= 3'h0;
      ADDRESS_STROBE_B <= 1'b1;
      ADDR_OE <= 1'b0;
      DATA_OE <= 1'b0;
      ADDR <= {AW{1'b0}};
      WDATA <= {DW{1'b0}};
      FUNC_CODE <= 3'h0;
      WRITE_OUT <= 1'b0;
      CYCLE_DONE <= 1'b0;
      FAULT_VEC_REQ <= 1'b0;
      LOAD_SSP <= 1'b0;
      LOAD_PC <= 1'b0;
      IPL_MASK <= `BFHRC_IPL_RESET;
      HALTED <= 1'b0;
      DOUBLE_FAULT <= 1'b0;
    end else begin
      CYCLE_DONE <= 1'b0;
      FAULT_VEC_REQ <= 1'b0;
      LOAD_SSP <= 1'b0;
      LOAD_PC <= 1'b0;
      if (INSN_START) begin
        fault_pend_q <= 1'b0;
        post_reset_q <= 1'b0;
      end
      case (st_q)
        S_IDLE: begin
          ADDR_OE <= 1'b0;
          DATA_OE <= 1'b0;
          HALTED <= hlt;
          // one cycle per step.
          // The core drops its request only on seeing the done pulse, so the
          // cycle right after that pulse must not take the old request again.
          if (!hlt && START_REQ && !CYCLE_DONE) begin
            addr_q <= REQ_ADDR;
            wd_q <= REQ_WDATA;
            fc_q <= REQ_FC;
            wr_q <= REQ_WRITE;
            rmw_q <= REQ_RMW;
            kind_q <= K_NORM;
            st_q <= S_BUS;
          end
        end
        S_VEC: begin
          // vector fetch as bus cycle.
          // The last acknowledge still sits in the synchroniser; wait until it
          // clears, or it would end the next fetch before the slave answers.
          st_q <= (hlt || ack) ? S_VEC : S_BUS;
        end
        S_RERUN: begin
          HALTED <= 1'b1;
          if (!hlt) begin
            HALTED <= 1'b0;
            st_q <= S_BUS;
          end
        end
        S_BUS: begin
          ADDR <= addr_q;
          WDATA <= wd_q;
          FUNC_CODE <= fc_q;
          WRITE_OUT <= wr_q;
          ADDR_OE <= 1'b1;
          DATA_OE <= wr_q;
          ADDRESS_STROBE_B <= 1'b0;
          if (!ADDRESS_STROBE_B && (ack || flt)) begin
            cnt_q <= 3'h0;
            st_q <= flt ? S_END : S_BUS;
            if (!flt) begin
              ADDRESS_STROBE_B <= 1'b1;
              CYCLE_DONE <= 1'b1;
              if (kind_q == K_SSP) begin
                LOAD_SSP <= 1'b1;
                kind_q <= K_PC;
                addr_q <= `BFHRC_VEC_PC;
                st_q <= S_VEC;
              end else if (kind_q == K_PC) begin
                LOAD_PC <= 1'b1;
                reset_seq_q <= 1'b0;
                st_q <= S_IDLE;
              end else if (kind_q == K_FVEC) begin
                FAULT_VEC_REQ <= 1'b1;
                st_q <= S_IDLE;
              end else if (stk_q != 3'h0) begin
                stk_q <= stk_q - 3'h1;
                st_q <= S_STACK;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
        end
        S_END: begin
          // strobe drops 3 clocks after fault, 2.5 rounded up.
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `BFHRC_STROBE_CYC - 1) begin
            ADDRESS_STROBE_B <= 1'b1;
            st_q <= S_FLOAT;
          end
        end
        S_FLOAT: begin
          ADDR_OE <= 1'b0;
          DATA_OE <= 1'b0;
          if (!flt) begin
            if (hlt && !rmw_q && kind_q == K_NORM && stk_q == 3'h0) begin
              // halted re-run wait; no fault counted.
              st_q <= S_RERUN;
            end else if (fault_pend_q || post_reset_q || reset_seq_q) begin
              st_q <= S_LOCK;
            end else begin
              fault_pend_q <= 1'b1;
              stk_q <= STACK_N[2:0];
              addr_q <= PC_IN;
              st_q <= S_STACK;
            end
          end
        end
        S_STACK: begin
          // push PC, status, error words.
          // Held halt stops stacking too, and a stale acknowledge must clear
          // first, so each stacked word gets an answer of its own.
          if (!hlt && !ack) begin
            if (stk_q == 3'h0) begin
              kind_q <= K_FVEC;
              addr_q <= `BFHRC_VEC_FAULT;
              wr_q <= 1'b0;
            end else begin
              kind_q <= K_NORM;
              addr_q <= addr_q - {{(AW-1){1'b0}}, 1'b1};
              wr_q <= 1'b1;
            end
            rmw_q <= 1'b0;
            fc_q <= 3'h5;
            st_q <= S_BUS;
          end
        end
        S_LOCK: begin
          HALTED <= 1'b1;
          DOUBLE_FAULT <= 1'b1;
          ADDR_OE <= 1'b0;
          DATA_OE <= 1'b0;
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== testbench/bfhrc_props_properties.sv ====
// Checker for fault, halt, wait and reset timing at the pins.
// Assumes one MCLK domain; bound to bfhrc_top after the module.
module bfhrc_props (
  // Clock and reset.
  input wire MCLK,
  input wire RST_B,
  // Watched pins.
  input wire TRANSFER_ACKNOWLEDGE_B,
  input wire BUS_FAULT_INPUT_B,
  input wire HALT_IN_B,
  input wire ADDRESS_STROBE_B,
  input wire ADDR_OE,
  input wire DATA_OE,
  input wire RESET_OE,
  input wire LOAD_PC,
  input wire [2:0] IPL_MASK,
  input wire HALTED,
  input wire ARB_TRISTATE,
  input wire CTRL_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rcnt_q;
  default clocking dck @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // Length of the reset pulse; cleared between pulses.
  always @(posedge MCLK) begin
    rcnt_q <= (!RST_B || !RESET_OE) ? 8'h0 : rcnt_q + 8'h1;
  end
  fault_strobe_end_a: assert property (
    $fell(BUS_FAULT_INPUT_B) && !ADDRESS_STROBE_B |-> ##[1:6] ADDRESS_STROBE_B)
    else $error("strobe kept after fault");
  fault_bus_float_a: assert property (
    (!BUS_FAULT_INPUT_B && ADDRESS_STROBE_B) [*3] |-> !ADDR_OE && !DATA_OE)
    else $error("buses driven during fault");
  arb_ctrl_float_a: assert property (
    $past(RST_B) |-> CTRL_OE == !$past(ARB_TRISTATE))
    else $error("control enable not following arbitration");
  halt_no_cycle_a: assert property (
    (!HALT_IN_B) [*5] ##0 ADDRESS_STROBE_B |=> ADDRESS_STROBE_B)
    else $error("cycle started while halted");
  halted_bus_float_a: assert property (
    HALTED && $past(HALTED) |-> !ADDR_OE && !DATA_OE)
    else $error("buses driven while halted");
  reset_ipl_seven_a: assert property (
    LOAD_PC |-> IPL_MASK == 3'h7)
    else $error("level not seven after reset");
  reset_pulse_len_a: assert property (
    $fell(RESET_OE) |-> rcnt_q == 8'h7c)
    else $error("reset pulse length wrong");
  reset_ipl_keep_a: assert property (
    RESET_OE |-> $stable(IPL_MASK))
    else $error("level changed by reset pulse");
  ack_wait_hold_a: assert property (
    (TRANSFER_ACKNOWLEDGE_B && BUS_FAULT_INPUT_B) [*4] ##0 !ADDRESS_STROBE_B
    |=> !ADDRESS_STROBE_B)
    else $error("cycle ended without answer");
endmodule

bind bfhrc_top bfhrc_props u_bfhrc_props (.MCLK, .RST_B, .TRANSFER_ACKNOWLEDGE_B,
  .BUS_FAULT_INPUT_B, .HALT_IN_B, .ADDRESS_STROBE_B, .ADDR_OE, .DATA_OE, .RESET_OE,
  .LOAD_PC, .IPL_MASK, .HALTED, .ARB_TRISTATE, .CTRL_OE);

// ==== testbench/bfhrc_slave.sv ====
// Slave answering bus cycles after a set wait, or never when nak is high.
// Assumes the bench changes wt and nak on rising edges.
module bfhrc_slave (
  // Clock and strobe.
  input wire clk,
  input wire as_b,
  // Bench controls.
  input wire nak,
  input wire [3:0] wt,
  // Answer, pulled up when released.
  output logic ack_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q = 4'h0;
  initial ack_b = 1'b1;
  // edge-timed answer
  // Rising-edge changes keep ack aligned with the bench's fault and halt.
  always @(posedge clk) begin
    cnt_q <= as_b ? 4'h0 : cnt_q + 4'h1;
    ack_b <= as_b || nak || cnt_q < wt;
  end
endmodule

// ==== testbench/tb_top.sv ====
// Bench for bfhrc_top: slave model plus fault, halt and reset stimulus.
// Assumes the checker is bound in by its own file.
`include "bfhrc_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_b = 0, halt_b = 1, flt_b = 1, rin_b = 1, arb = 0, start = 0;
  logic wr = 0, rmw = 0, insn = 0, rinsn = 0, nak = 0, mon_on = 1, as_p = 1;
  logic [23:0] ra = 0, la;
  logic [7:0] rd = 0;
  logic [2:0] fc = 0;
  logic [3:0] wt = 0;
  logic [36:0] e;
  logic [36:0] q[$];
  wire ack_b, hob, hoe, rob, roe, as_b, aoe, doe, wo, done, fvr, lpc, halted, dbl, lss;
  wire [23:0] addr;
  wire [7:0] wd;
  wire [2:0] fco, ipl;
  integer err_count = 0, check_count = 0, seed = 51386, n, i, nst = 0;
  always #25 mclk = ~mclk;
  bfhrc_top u_bfhrc_top (.MCLK(mclk), .RST_B(rst_b), .TRANSFER_ACKNOWLEDGE_B(ack_b),
    .BUS_FAULT_INPUT_B(flt_b), .HALT_IN_B(hoe ? hob : halt_b), .HALT_OUT_B(hob),
    .HALT_OE(hoe), .RESET_IN_B(roe ? rob : rin_b), .RESET_OUT_B(rob), .RESET_OE(roe),
    .ADDRESS_STROBE_B(as_b), .ARB_TRISTATE(arb), .CTRL_OE(), .ADDR(addr), .ADDR_OE(aoe),
    .WDATA(wd), .DATA_OE(doe), .FUNC_CODE(fco), .WRITE_OUT(wo), .START_REQ(start),
    .REQ_ADDR(ra), .REQ_WDATA(rd), .REQ_FC(fc), .REQ_WRITE(wr), .REQ_RMW(rmw),
    .INSN_START(insn), .RESET_INSN(rinsn), .PC_IN(24'h000400), .CYCLE_DONE(done),
    .FAULT_VEC_REQ(fvr), .LOAD_SSP(lss), .LOAD_PC(lpc), .IPL_MASK(ipl), .HALTED(halted),
    .DOUBLE_FAULT(dbl));
  bfhrc_slave u_bfhrc_slave (.clk(mclk), .as_b(as_b), .nak(nak), .wt(wt), .ack_b(ack_b));
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [35:0] g, input logic [35:0] x);
    check_count++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask
  function automatic logic ev(input int k);
    logic [7:0] s;
    s = {lss, roe, dbl, as_b, !as_b, lpc, fvr, done};
    ev = s[k];
  endfunction
  // Bounded wait; a hang is a mismatch.
  task automatic wt_ev(input int k);
    int c;
    c = 0;
    while (ev(k) !== 1'b1 && c < 600) begin
      @(posedge mclk);
      c++;
    end
    if (c >= 600) begin
      err_count++;
      final_report();
    end
  endtask
  task automatic req(input logic w, input logic m);
    logic [23:0] a;
    logic [7:0] d;
    logic [2:0] f;
    a = 24'($random(seed));
    d = 8'($random(seed));
    f = 3'h1 + 3'($random(seed) & 1);
    @(posedge mclk);
    {ra, rd, fc, wr, rmw, start} <= {a, d, f, w, m, 1'b1};
    wt <= 4'($random(seed) & 3);
    arb <= 1'($random(seed));
    q.push_back({1'b1, f, w, w ? d : 8'h0, a});
  endtask
  task automatic fin();
    wt_ev(0);
    start <= 1'b0;
  endtask
  task automatic vec();
    q.push_back({13'h0, `BFHRC_VEC_SSP});
    q.push_back({13'h0, `BFHRC_VEC_PC});
    wt_ev(7);
    wt_ev(2);
    cmp(36'(ipl), 36'(`BFHRC_IPL_RESET));
  endtask
  // Strobe watcher: with mon_on set, each started cycle is checked against the oldest note.
  always @(posedge mclk) begin
    as_p <= as_b;
    if (as_p && !as_b && rst_b) begin
      if (!mon_on) begin
        nst <= nst + 1;
        la <= addr;
      end else if (q.size() == 0) cmp(36'h0, 36'hfffffffff);
      else begin
        e = q.pop_front();
        cmp({e[36] ? fco : 3'h0, wo, wo ? wd : 8'h0, addr}, e[35:0]);
      end
    end
  end
  initial begin
    // power-up reset hold.
    // The hold is shortened to 20 clocks; the full time is too long to run.
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    vec();
    insn <= 1'b1;
    @(posedge mclk);
    insn <= 1'b0;
    for (i = 0; i < 6; i++) begin
      req(i[0], 1'b0);
      fin();
    end
    nak <= 1'b1;
    req(1'b1, 1'b0);
    q.push_back(q[$]);
    q.push_back(q[$]);
    repeat (2) begin
      wt_ev(3);
      {halt_b, flt_b} <= 2'b00;
      wt_ev(4);
      flt_b <= 1'b1;
      repeat (2) @(posedge mclk);
      halt_b <= 1'b1;
    end
    nak <= 1'b0;
    fin();
    cmp(36'(dbl), 36'h0);
    halt_b <= 1'b0;
    repeat (4) @(posedge mclk);
    req(1'b0, 1'b0);
    repeat (20) @(posedge mclk);
    cmp(36'(as_b), 36'h1);
    halt_b <= 1'b1;
    wt_ev(3);
    halt_b <= 1'b0; // halt ahead of acknowledge
    fin();
    req(1'b1, 1'b0);
    repeat (20) @(posedge mclk);
    cmp(36'({as_b, aoe, doe}), 36'h4);
    halt_b <= 1'b1;
    fin();
    rinsn <= 1'b1;
    @(posedge mclk);
    rinsn <= 1'b0;
    wt_ev(6);
    n = 0;
    while (roe === 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    cmp(36'(n), 36'h7c);
    // fault with halt on a locked cycle
    {mon_on, nak} <= 2'b01;
    req(1'b0, 1'b1);
    wt_ev(3);
    {halt_b, flt_b} <= 2'b00;
    wt_ev(4);
    repeat (4) @(posedge mclk);
    cmp(36'({aoe, doe}), 36'h0);
    nst = 0;
    {nak, flt_b, start} <= 3'b010;
    repeat (2) @(posedge mclk);
    halt_b <= 1'b1;
    wt_ev(1);
    cmp(36'(nst), 36'(`BFHRC_STACK_WORDS + 1));
    cmp(36'(la), 36'(`BFHRC_VEC_FAULT));
    nak <= 1'b1;
    req(1'b0, 1'b0);
    wt_ev(3);
    flt_b <= 1'b0;
    wt_ev(4);
    flt_b <= 1'b1;
    wt_ev(5);
    cmp(36'(halted), 36'h1);
    {flt_b, nak, start} <= 3'b100;
    q.delete();
    {halt_b, rin_b} <= 2'b00;
    repeat (12) @(posedge mclk);
    {halt_b, rin_b, mon_on} <= 3'b111;
    vec();
    cmp(36'(dbl), 36'h0);
    {mon_on, nak, rst_b} <= 3'b010;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    wt_ev(3);
    flt_b <= 1'b0;
    wt_ev(4);
    flt_b <= 1'b1;
    wt_ev(5);
    cmp(36'(dbl), 36'h1);
    final_report();
  end
endmodule
